// ---- src/global_config_registers.sv ----
// Chip-level configuration bank, indices 0x00 to 0x2F, behind an index/data port.
// Assumes host I/O strobes, config_mode and the reset inputs share clk;
// indices 0x30 and up are forwarded to per-device banks outside this block.
`timescale 1ns/100ps

// What this block does
// - Index port decodes all eight bits
// - Global group spans indices zero to 0x2F
// - Unimplemented registers or bits read zero
// - Data port reaches the currently indexed register
// - Ports respond only in configuration mode
// - Listed reserved indices ignore writes, read zero
// - Control bit 0 triggers self-clearing soft reset
// - 0x07 selects logical device for banks
// - Activation reaches only the selected device
// - 0x20 returns fixed identification code
// - 0x21 returns fixed silicon revision
// - 0x22 holds one power bit per function
// - 0x23 enables automatic power management
// - Oscillator register resets to 0x44
// - Address low byte keeps bit 0 zero
// - Strap picks 0x2E or 0x4E default
// - Port moves when high byte written
// - Serial 2 power reset by standby only
module global_config_registers #(
    parameter logic [7:0] DEVICE_IDENTIFICATION_CODE = 8'hA5,   // Arbitrary value
    parameter logic [7:0] SILICON_REV    = 8'h01    // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        hard_reset_n,
    input  wire logic        standby_por_n,
    input  wire logic        sysopt_pin,
    input  wire logic        config_mode,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_rdata_valid,
    output logic      [15:0] config_base_addr,
    output logic             soft_reset_pulse,
    output logic      [7:0]  logical_device_sel,
    output logic      [7:0]  function_power_enable,
    output logic      [7:0]  auto_power_enable,
    output logic      [7:0]  oscillator_ctrl,
    output logic      [7:0]  ld_index,
    output logic      [7:0]  ld_wdata,
    output logic             ld_wr,
    output logic             ld_rd,
    input  wire logic [7:0]  ld_rdata
);

    // ==========================================================
    // Declarations
    cfg_access_if acc ();

    logic        rst_main;
    logic        rst_standby;
    logic        strap_high;

    logic [7:0]  rdata_reg;
    logic        rdata_valid_reg;
    logic [15:0] base_addr_reg;
    logic        soft_pulse_reg;
    logic [7:0]  ldev_sel_reg;
    logic [7:0]  function_power_enable_reg;
    logic [7:0]  auto_pwr_reg;
    logic [7:0]  osc_reg;
    logic [7:0]  addr_low_reg;
    logic [7:0]  config_port_address_high_reg;
    logic [7:0]  ld_wdata_reg;
    logic        ld_wr_reg;
    logic        ld_rd_reg;

    logic        in_bank;
    logic        wr_ctrl;
    logic        wr_ldev;
    logic        wr_power;
    logic        wr_apm;
    logic        wr_osc;
    logic        wr_addr_low;
    logic        wr_addr_high;
    logic        soft_request;
    logic [7:0]  rd_mux;
    logic [7:0]  rdata_next;
    logic [7:0]  addr_low_default;
    logic [7:0]  power_next;

    // ==========================================================
    // Submodules
    reset_sequencer u_reset (
        .clk           (clk),
        .rstn          (rstn),
        .hard_reset_n  (hard_reset_n),
        .standby_por_n (standby_por_n),
        .sysopt_pin    (sysopt_pin),
        .rst_main      (rst_main),
        .rst_standby   (rst_standby),
        .strap_high    (strap_high)
    );

    config_port_decode u_decode (
        .clk         (clk),
        .rst_main    (rst_main),
        .config_mode (config_mode),
        .io_addr     (io_addr),
        .io_wr       (io_wr),
        .io_rd       (io_rd),
        .io_wdata    (io_wdata),
        .base_addr   (base_addr_reg),
        .acc         (acc.source)
    );

    // ==========================================================
    // Write decode
    // upper index split
    assign in_bank      = acc.index > cfg_regs_pkg::IDX_GLOBAL_LAST;
    assign wr_ctrl      = acc.data_wr && (acc.index == cfg_regs_pkg::IDX_CONFIG_CONTROL);
    assign wr_ldev      = acc.data_wr && (acc.index == cfg_regs_pkg::IDX_LDEV_SELECT);
    assign wr_power     = acc.data_wr && (acc.index == cfg_regs_pkg::IDX_FUNC_POWER);
    assign wr_apm       = acc.data_wr && (acc.index == cfg_regs_pkg::IDX_AUTO_PWR_MGMT);
    assign wr_osc       = acc.data_wr && (acc.index == cfg_regs_pkg::IDX_OSC_CONTROL);
    assign wr_addr_low  = acc.data_wr && (acc.index == cfg_regs_pkg::IDX_ADDR_LOW);
    assign wr_addr_high = acc.data_wr && (acc.index == cfg_regs_pkg::IDX_ADDR_HIGH);
    assign soft_request = wr_ctrl && acc.wdata[cfg_regs_pkg::SOFT_RESET_BIT];

    // ==========================================================
    // Read selection
    // unmapped reads zero
    assign rd_mux =
        in_bank ? ld_rdata :
        (acc.index == cfg_regs_pkg::IDX_LDEV_SELECT)   ? ldev_sel_reg :
        (acc.index == cfg_regs_pkg::IDX_DEVICE_IDENTIFICATION)     ? DEVICE_IDENTIFICATION_CODE :
        (acc.index == cfg_regs_pkg::IDX_SILICON_REV)   ? SILICON_REV :
        (acc.index == cfg_regs_pkg::IDX_FUNC_POWER)    ? function_power_enable_reg :
        (acc.index == cfg_regs_pkg::IDX_AUTO_PWR_MGMT) ? auto_pwr_reg :
        (acc.index == cfg_regs_pkg::IDX_OSC_CONTROL)   ? osc_reg :
        (acc.index == cfg_regs_pkg::IDX_ADDR_LOW)      ? addr_low_reg :
        (acc.index == cfg_regs_pkg::IDX_ADDR_HIGH)     ? config_port_address_high_reg :
        cfg_regs_pkg::READ_ZERO;

    // Index-port reads return the index itself, data-port reads the selected register; otherwise hold the last answer
    assign rdata_next = acc.index_rd ? acc.index :
                        acc.data_rd  ? rd_mux : rdata_reg;

    assign addr_low_default = strap_high ? cfg_regs_pkg::ADDR_LOW_STRAP1
                                         : cfg_regs_pkg::ADDR_LOW_STRAP0;

    assign power_next = acc.wdata & cfg_regs_pkg::FUNC_POWER_MASK;

    // ==========================================================
    // Read answer, one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst_main) begin
            rdata_reg       <= 8'h00;
            rdata_valid_reg <= 1'b0;
        end else begin
            rdata_reg       <= rdata_next;
            rdata_valid_reg <= acc.data_rd || acc.index_rd;
        end
    end

    // ==========================================================
    // Soft reset trigger
    // self-clearing soft reset
    // Reads of the control register return zero, so no state is kept for it
    always_ff @(posedge clk) begin
        if (rst_main || rst_standby) begin
            soft_pulse_reg <= 1'b0;
        end else begin
            soft_pulse_reg <= soft_request && !soft_pulse_reg;
        end
    end

    // ==========================================================
    // Logical device selector, cleared by every reset type
    // device bank selector
    always_ff @(posedge clk) begin
        if (rst_main || rst_standby || soft_pulse_reg) begin
            ldev_sel_reg <= cfg_regs_pkg::LDEV_SELECT_RST;
        end else if (wr_ldev) begin
            ldev_sel_reg <= acc.wdata;
        end
    end

    // ==========================================================
    // Function power enables; serial port 2 survives all but standby reset
    // one means powered
    always_ff @(posedge clk) begin
        if (rst_standby) begin
            function_power_enable_reg <= cfg_regs_pkg::FUNC_POWER_RST;
        end else if (rst_main || soft_pulse_reg) begin
            function_power_enable_reg <= cfg_regs_pkg::FUNC_POWER_RST;
            function_power_enable_reg[cfg_regs_pkg::SERIAL2_POWER_BIT] <=
                function_power_enable_reg[cfg_regs_pkg::SERIAL2_POWER_BIT];
        end else if (wr_power) begin
            function_power_enable_reg <= power_next;
        end
    end

    // ==========================================================
    // Automatic power management and oscillator; soft reset leaves both
    // per-function auto power
    always_ff @(posedge clk) begin
        if (rst_main || rst_standby) begin
            auto_pwr_reg <= cfg_regs_pkg::AUTO_PWR_RST;
            osc_reg      <= cfg_regs_pkg::OSC_RST;
        end else begin
            if (wr_apm) begin
                auto_pwr_reg <= acc.wdata & cfg_regs_pkg::AUTO_PWR_MASK;
            end
            if (wr_osc) begin
                osc_reg <= (acc.wdata & cfg_regs_pkg::OSC_MASK);
            end
        end
    end

    // ==========================================================
    // Configuration port address
    // Only main-supply and hard resets restore it; a soft reset must not
    // move the port under the feet of software still in configuration mode.
    // even port address
    always_ff @(posedge clk) begin
        if (rst_main) begin
            addr_low_reg                 <= addr_low_default;
            config_port_address_high_reg <= cfg_regs_pkg::ADDR_HIGH_RST;
            base_addr_reg <= {cfg_regs_pkg::ADDR_HIGH_RST, addr_low_default};
        end else begin
            if (wr_addr_low) begin
                addr_low_reg <= acc.wdata & cfg_regs_pkg::ADDR_LOW_MASK;
            end
            if (wr_addr_high) begin
                config_port_address_high_reg <= acc.wdata;
                base_addr_reg <= {acc.wdata, addr_low_reg};
            end
        end
    end

    // ==========================================================
    // Forwarding to the per-device banks
    // bank access follows selector
    always_ff @(posedge clk) begin
        if (rst_main || rst_standby) begin
            ld_wdata_reg <= 8'h00;
            ld_wr_reg    <= 1'b0;
            ld_rd_reg    <= 1'b0;
        end else begin
            ld_wdata_reg <= acc.wdata;
            ld_wr_reg    <= acc.data_wr && in_bank;
            ld_rd_reg    <= acc.data_rd && in_bank;
        end
    end

    // ==========================================================
    // Outputs, each from a flop
    assign io_rdata              = rdata_reg;
    assign io_rdata_valid        = rdata_valid_reg;
    assign config_base_addr      = base_addr_reg;
    assign soft_reset_pulse      = soft_pulse_reg;
    assign logical_device_sel    = ldev_sel_reg;
    assign function_power_enable = function_power_enable_reg;
    assign auto_power_enable     = auto_pwr_reg;
    assign oscillator_ctrl       = osc_reg;
    assign ld_index              = acc.index;
    assign ld_wdata              = ld_wdata_reg;
    assign ld_wr                 = ld_wr_reg;
    assign ld_rd                 = ld_rd_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    logic idx_reserved;
    assign idx_reserved = (acc.index <= 8'h01) ||
                          ((acc.index >= 8'h03) && (acc.index <= 8'h06)) ||
                          ((acc.index >= 8'h08) && (acc.index <= 8'h1F)) ||
                          (acc.index == 8'h25);

    chk_index_full: assert property (
        (io_wr && config_mode && io_addr == base_addr_reg && hard_reset_n)
        |=> (acc.index == $past(io_wdata)))
        else $error("index port lost bits");

    chk_reserved_zero: assert property (
        (acc.data_rd && idx_reserved) |=> (io_rdata_valid && io_rdata == 8'h00))
        else $error("reserved index read nonzero");

    chk_mode_gate: assert property (
        !config_mode |-> !(acc.data_wr || acc.data_rd || acc.index_rd))
        else $error("port answered outside configuration mode");

    chk_soft_trigger: assert property (
        (soft_request && !soft_pulse_reg && hard_reset_n && standby_por_n)
        |=> soft_reset_pulse ##1 (!soft_reset_pulse && logical_device_sel == 8'h00))
        else $error("soft reset did not run or clear");

    chk_id_read: assert property (
        (acc.data_rd && acc.index == 8'h20) |=> (io_rdata == DEVICE_IDENTIFICATION_CODE))
        else $error("identification code wrong");

    chk_rev_read: assert property (
        (acc.data_rd && acc.index == 8'h21) |=> (io_rdata == SILICON_REV))
        else $error("revision code wrong");

    chk_power_reserved: assert property (
        (function_power_enable[1] == 1'b0) && (function_power_enable[7] == 1'b0))
        else $error("reserved power bit set");

    chk_addr_even: assert property (
        config_base_addr[0] == 1'b0)
        else $error("configuration port address odd");

    chk_base_move: assert property (
        (wr_addr_high && hard_reset_n) |=>
        (config_base_addr == {$past(acc.wdata), $past(addr_low_reg)}))
        else $error("port did not move on high byte");

    chk_serial2_keep: assert property (
        (soft_pulse_reg && standby_por_n && !wr_power) |=>
        $stable(function_power_enable[5]))
        else $error("serial 2 power lost on soft reset");

    chk_bank_route: assert property (
        (acc.data_wr && in_bank && hard_reset_n && standby_por_n) |=>
        (ld_wr && ld_wdata == $past(acc.wdata)))
        else $error("bank write not forwarded");

    cov_soft_reset: cover property (soft_request ##1 soft_reset_pulse);
    cov_port_move:  cover property (wr_addr_low ##[1:20] wr_addr_high);
    cov_bank_read:  cover property (acc.data_rd && in_bank ##1 io_rdata_valid);
    cov_id_read:    cover property (acc.data_rd && acc.index == 8'h20);

endmodule // global_config_registers

// ---- src/cfg_regs_pkg.sv ----
// Offsets, field masks and reset values of the chip-level configuration bank.
// Assumes an 8-bit index space whose upper part (0x30 up) belongs to device banks.
package cfg_regs_pkg;

    // ==========================================================
    // Register indices
    localparam logic [7:0] IDX_CONFIG_CONTROL = 8'h02;
    localparam logic [7:0] IDX_LDEV_SELECT    = 8'h07;
    localparam logic [7:0] IDX_DEVICE_IDENTIFICATION      = 8'h20;
    localparam logic [7:0] IDX_SILICON_REV    = 8'h21;
    localparam logic [7:0] IDX_FUNC_POWER     = 8'h22;
    localparam logic [7:0] IDX_AUTO_PWR_MGMT  = 8'h23;
    localparam logic [7:0] IDX_OSC_CONTROL    = 8'h24;
    localparam logic [7:0] IDX_ADDR_LOW       = 8'h26;
    localparam logic [7:0] IDX_ADDR_HIGH      = 8'h27;
    localparam logic [7:0] IDX_GLOBAL_LAST    = 8'h2F;

    // ==========================================================
    // Field positions and writable-bit masks
    localparam int         SOFT_RESET_BIT     = 0;
    localparam int         SERIAL2_POWER_BIT  = 5;
    localparam logic [7:0] FUNC_POWER_MASK    = 8'h7D;
    localparam logic [7:0] AUTO_PWR_MASK      = 8'h79;
    localparam logic [7:0] OSC_MASK           = 8'hFE;
    localparam logic [7:0] ADDR_LOW_MASK      = 8'hFE;

    // ==========================================================
    // Reset values
    localparam logic [7:0] LDEV_SELECT_RST    = 8'h00;
    localparam logic [7:0] FUNC_POWER_RST     = 8'h00;
    localparam logic [7:0] AUTO_PWR_RST       = 8'h00;
    localparam logic [7:0] OSC_RST            = 8'h44;
    localparam logic [7:0] ADDR_LOW_STRAP0    = 8'h2E;
    localparam logic [7:0] ADDR_LOW_STRAP1    = 8'h4E;
    localparam logic [7:0] ADDR_HIGH_RST      = 8'h00;
    localparam logic [7:0] READ_ZERO          = 8'h00;

endpackage

// ---- src/cfg_access_if.sv ----
// Carries decoded index- and data-port accesses from the port decoder to the register bank.
// Assumes both ends share one clock; all signals but index are same-cycle combinational.
`timescale 1ns/100ps

interface cfg_access_if;
    logic [7:0] index;     // Current index, from a flop in the decoder
    logic       data_wr;   // Data-port write this cycle
    logic       data_rd;   // Data-port read this cycle
    logic       index_rd;  // Index-port read this cycle
    logic [7:0] wdata;     // Write data of the host cycle

    modport source (output index, output data_wr, output data_rd,
                    output index_rd, output wdata);
    modport sink   (input index, input data_wr, input data_rd,
                    input index_rd, input wdata);
endinterface // cfg_access_if

// ---- src/config_port_decode.sv ----
// Index/data port decoder: matches host I/O cycles against the configuration port.
// Assumes io_* strobes are one-cycle pulses from same-clock bus logic.
`timescale 1ns/100ps

module config_port_decode (
    input  wire logic        clk,
    input  wire logic        rst_main,
    input  wire logic        config_mode,
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    input  wire logic [15:0] base_addr,
    cfg_access_if.source     acc
);

    logic [7:0] index_reg;
    logic       hit_index;
    logic       hit_data;

    // ==========================================================
    // Port matching
    // Outside configuration mode neither port exists, so cycles pass untouched
    // mode gates ports
    assign hit_index = config_mode && (io_addr == base_addr);
    assign hit_data  = config_mode && (io_addr == {base_addr[15:1], 1'b1});

    // full index kept
    // All eight index bits are kept; no aliasing of the register space
    always_ff @(posedge clk) begin
        if (rst_main) begin
            index_reg <= 8'h00;
        end else if (io_wr && hit_index) begin
            index_reg <= io_wdata;
        end
    end

    // Access strobes towards the bank
    assign acc.index    = index_reg;
    assign acc.data_wr  = io_wr && hit_data;
    assign acc.data_rd  = io_rd && hit_data;
    assign acc.index_rd = io_rd && hit_index;
    assign acc.wdata    = io_wdata;

endmodule // config_port_decode

// ---- src/reset_sequencer.sv ----
// Combines the reset sources and synchronises the address strap pin.
// Assumes hard_reset_n and standby_por_n come from same-clock logic.
`timescale 1ns/100ps

module reset_sequencer (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic hard_reset_n,
    input  wire logic standby_por_n,
    input  wire logic sysopt_pin,
    output logic      rst_main,
    output logic      rst_standby,
    output logic      strap_high
);

    logic strap_meta_reg;
    logic strap_sync_reg;

    // ==========================================================
    // Strap synchroniser
    // Not reset: the strap must be valid while rstn is still held
    always_ff @(posedge clk) begin
        strap_meta_reg <= sysopt_pin;
        strap_sync_reg <= strap_meta_reg;
    end

    // Reset groups: main supply or hard reset, and standby supply
    assign rst_main    = !rstn || !hard_reset_n;
    assign rst_standby = !standby_por_n;
    assign strap_high  = strap_sync_reg;

endmodule // reset_sequencer

// ---- dv/global_config_registers_test.sv ----
// Self-checking bench for the chip-level configuration bank.
// Assumes the bank sits at index port 0x2E after reset with the strap low.
`timescale 1ns/100ps

module global_config_registers_test;

    // ==========================================================
    // Stimulus and observed signals
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        hard_reset_n = 1'b1;
    logic        standby_por_n = 1'b1;
    logic        sysopt_pin = 1'b0;
    logic        config_mode = 1'b1;
    logic [15:0] io_addr = 16'h0000;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic [7:0]  io_wdata = 8'h00;
    logic [7:0]  ld_rdata = 8'h3C;
    logic [7:0]  io_rdata, logical_device_sel, function_power_enable;
    logic [7:0]  auto_power_enable, oscillator_ctrl, ld_index, ld_wdata;
    logic [15:0] config_base_addr;
    logic        io_rdata_valid, soft_reset_pulse, ld_wr, ld_rd;
    logic [15:0] base = 16'h002E;
    logic [7:0]  c_dat;
    logic        c_val, c_soft, c_lwr, c_lrd;
    int          n_fail = 0;
    int          checks = 0;
    int          cycles = 0;

    typedef struct {logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} row_type;
    row_type rows [15] = '{
        '{8'h00, 8'hFF, 8'h00}, '{8'h01, 8'hFF, 8'h00}, '{8'h03, 8'hFF, 8'h00},
        '{8'h06, 8'hFF, 8'h00}, '{8'h08, 8'hFF, 8'h00}, '{8'h1F, 8'hFF, 8'h00},
        '{8'h25, 8'hFF, 8'h00}, '{8'h02, 8'h00, 8'h00}, '{8'h07, 8'h5A, 8'h5A},
        '{8'h22, 8'hFF, 8'h7D}, '{8'h23, 8'hFF, 8'h79}, '{8'h24, 8'hFF, 8'hFE},
        '{8'h20, 8'hFF, 8'hA5}, '{8'h21, 8'hFF, 8'h01}, '{8'h26, 8'h2F, 8'h2E}};

    global_config_registers u_dut (
        .clk, .rstn, .hard_reset_n, .standby_por_n, .sysopt_pin, .config_mode,
        .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rdata_valid,
        .config_base_addr, .soft_reset_pulse, .logical_device_sel,
        .function_power_enable, .auto_power_enable, .oscillator_ctrl,
        .ld_index, .ld_wdata, .ld_wr, .ld_rd, .ld_rdata);

    // ==========================================================
    // Clock and hang guard; whole run needs well under 1000 cycles
    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            final_report();
        end
    end

    // ==========================================================
    // Host cycles: one strobe cycle, then one idle cycle so strobes never
    // toggle twice in one time step; answers are caught in the cycle after
    task automatic acc(input logic wr, input logic dport, input logic [7:0] d);
        io_addr <= base + {15'h0000, dport};
        io_wr <= wr;
        io_rd <= !wr;
        io_wdata <= d;
        @(posedge clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        #1;
        c_val = io_rdata_valid;
        c_dat = io_rdata;
        c_soft = soft_reset_pulse;
        c_lwr = ld_wr;
        c_lrd = ld_rd;
        @(posedge clk);
    endtask

    task automatic wreg(input logic [7:0] i, input logic [7:0] d);
        acc(1'b1, 1'b0, i);
        acc(1'b1, 1'b1, d);
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (e !== g) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rchk(input logic [7:0] i, input logic [7:0] e);
        acc(1'b1, 1'b0, i);
        acc(1'b0, 1'b1, 8'h00);
        chk("read valid", 16'h0001, {15'h0000, c_val});
        chk("read data", {8'h00, e}, {8'h00, c_dat});
    endtask

    // Reset pulse: 0 main, 1 hard, 2 standby
    task automatic pulse(input int w);
        if (w == 0) rstn <= 1'b0;
        else if (w == 1) hard_reset_n <= 1'b0;
        else standby_por_n <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        hard_reset_n <= 1'b1;
        standby_por_n <= 1'b1;
        @(posedge clk);
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ==========================================================
    // Main sequence: table of register cases first, then edge cases
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("base", 16'h002E, config_base_addr);
        chk("osc", 16'h0044, {8'h00, oscillator_ctrl});
        chk("power", 16'h0000, {8'h00, function_power_enable});
        $display("test reset done");
        foreach (rows[k]) begin
            wreg(rows[k].idx, rows[k].wd);
            rchk(rows[k].idx, rows[k].exp);
        end
        chk("power port", 16'h007D, {8'h00, function_power_enable});
        chk("apm port", 16'h0079, {8'h00, auto_power_enable});
        chk("ldev port", 16'h005A, {8'h00, logical_device_sel});
        $display("test register table done");
        // Index read back, then writes and reads with the mode off
        acc(1'b1, 1'b0, 8'h23);
        acc(1'b0, 1'b0, 8'h00);
        chk("index read", 16'h0023, {8'h00, c_dat});
        config_mode <= 1'b0;
        wreg(8'h22, 8'h00);
        acc(1'b0, 1'b1, 8'h00);
        chk("mode off valid", 16'h0000, {15'h0000, c_val});
        chk("mode off power", 16'h007D, {8'h00, function_power_enable});
        config_mode <= 1'b1;
        acc(1'b0, 1'b1, 8'h00);
        chk("index kept", 16'h0079, {8'h00, c_dat});
        $display("test mode gating done");
        // Bank traffic above 0x2F; 0xA2 must not alias onto 0x22
        wreg(8'h30, 8'h01);
        chk("bank wr", 16'h0001, {15'h0000, c_lwr});
        chk("bank idx", 16'h0030, {8'h00, ld_index});
        chk("bank wd", 16'h0001, {8'h00, ld_wdata});
        wreg(8'hA2, 8'h00);
        chk("alias power", 16'h007D, {8'h00, function_power_enable});
        acc(1'b0, 1'b1, 8'h00);
        chk("bank rd", 16'h0001, {15'h0000, c_lrd});
        chk("bank data", 16'h003C, {8'h00, c_dat});
        $display("test bank access done");
        // Soft reset keeps power bit 5, management, oscillator
        wreg(8'h02, 8'h01);
        chk("soft pulse", 16'h0001, {15'h0000, c_soft});
        // Soft values land on the edge the task returns on; look just after it
        #1;
        chk("soft end", 16'h0000, {15'h0000, soft_reset_pulse});
        chk("soft ldev", 16'h0000, {8'h00, logical_device_sel});
        chk("soft power", 16'h0020, {8'h00, function_power_enable});
        chk("soft apm", 16'h0079, {8'h00, auto_power_enable});
        @(posedge clk);
        rchk(8'h02, 8'h00);
        $display("test soft reset done");
        // Relocation moves only when the high byte lands
        wreg(8'h26, 8'h4F);
        chk("base low only", 16'h002E, config_base_addr);
        wreg(8'h27, 8'h03);
        base = 16'h034E;
        chk("base moved", 16'h034E, config_base_addr);
        rchk(8'h26, 8'h4E);
        rchk(8'h27, 8'h03);
        $display("test relocation done");
        // Standby reset clears power bit 5 but keeps the address
        pulse(2);
        chk("sb power", 16'h0000, {8'h00, function_power_enable});
        chk("sb base", 16'h034E, config_base_addr);
        chk("sb osc", 16'h0044, {8'h00, oscillator_ctrl});
        wreg(8'h22, 8'h7D);
        pulse(1);
        base = 16'h002E;
        chk("hard power", 16'h0020, {8'h00, function_power_enable});
        chk("hard base", 16'h002E, config_base_addr);
        chk("hard apm", 16'h0000, {8'h00, auto_power_enable});
        sysopt_pin <= 1'b1;
        repeat (2) @(posedge clk);
        pulse(0);
        base = 16'h004E;
        chk("strap base", 16'h004E, config_base_addr);
        rchk(8'h26, 8'h4E);
        $display("test reset kinds done");
        final_report();
    end

endmodule // global_config_registers_test
